// *** common/idio_pkg.sv ***
// constants and carrier types for the instrument digital i/o ports
// assumes a single 40 mhz clock and byte-wide i/o cycles from the processor
package idio_pkg;

   // ----------------------------------------
   // i/o map
   // ----------------------------------------
   localparam int        IDIO_ADDR_W          = 10;
   localparam logic [9:0] IDIO_OFS_GROUP_A     = 10'h321;
   localparam logic [9:0] IDIO_OFS_INTERNAL    = 10'h322;
   localparam logic [9:0] IDIO_OFS_STATUS_A    = 10'h323;
   localparam logic [9:0] IDIO_OFS_STATUS_B    = 10'h324;
   localparam logic [9:0] IDIO_OFS_GROUP_B     = 10'h325;
   localparam logic [6:0] IDIO_RELAY_I2C_ADDR  = 7'h44;

   // ----------------------------------------
   // field layout and reset values
   // ----------------------------------------
   localparam int         IDIO_IN_W            = 6;
   localparam int         IDIO_OUT_B_W         = 4;
   localparam logic [1:0] IDIO_IN_PAD          = 2'h3;
   localparam logic [3:0] IDIO_OUT_B_PAD       = 4'hf;
   localparam logic [7:0] IDIO_RELEASED        = 8'hff;
   localparam logic [7:0] IDIO_UNMAPPED_RD     = 8'hff;
   localparam int         IDIO_RELAY_WDOG_BIT  = 0;
   localparam int         IDIO_RELAY_PUMP_BIT  = 1;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam longint     IDIO_CLK_HZ          = 40000000;
   localparam longint     IDIO_WDOG_TIME_MS    = 5000;
   localparam int         IDIO_WDOG_CYC        = int'((IDIO_WDOG_TIME_MS * IDIO_CLK_HZ) / 1000);

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [2:0] {
      IDIO_SEL_GROUP_A,
      IDIO_SEL_INTERNAL,
      IDIO_SEL_STATUS_A,
      IDIO_SEL_STATUS_B,
      IDIO_SEL_GROUP_B,
      IDIO_SEL_NONE
   } idio_sel_t;

   typedef struct packed {
      logic                   rd;
      logic                   wr;
      logic [IDIO_ADDR_W-1:0] addr;
      logic [7:0]             wdata;
   } idio_io_req_t;

   typedef struct packed {
      logic [1:0] spare_hi;
      logic       pressure_alarm_indicator;
      logic       thermal_alarm_indicator;
      logic       diagnostic_indicator;
      logic       sequence_running_indicator;
      logic       spare_lo;
      logic       health_indicator;
   } idio_status_t;

endpackage : idio_pkg

// *** hw/idio_ports.sv ***
// byte-wide i/o mapped digital ports of the instrument processor
// assumes synchronous i/o strobes and pins sampled on the same clock
//
// What this block does
// R1: port a read gives six active-low inputs on bits 0-5, bits 6-7 one.
// R2: port b read gives next six active-low inputs, upper two bits one.
// R3: port a write drives eight active-low outputs from bits 0-7.
// R4: port b write drives four active-low outputs from bits 0-3.
// R5: internal input port readable at its location, all eight bits spare.
// R6: internal output port writable at the same location, bits spare.
// R7: status bit 0 low when healthy, high on any alarm or diagnostics.
// R8: status bit 2 low while a calibration sequence runs.
// R9: status bit 3 low while in diagnostic mode.
// R10: status bit 4 low on any temperature alarm.
// R11: status bit 5 low on any pressure alarm; bits 6-7 spare.
// R12: second status port accepts writes, all eight bits spare.
// R13: controller toggles relay watchdog bit at least every five seconds.
// R14: relay expander bit 1 low turns the zero air pump on.
// R15: port output bits hold their last written value until rewritten; relay pins release when the watchdog expires.
`timescale 1ns/1ps
module idio_ports #(
   parameter int WDOG_CYC = idio_pkg::IDIO_WDOG_CYC
) (
   // clock and reset
   input  wire logic                   i_clk,
   input  wire logic                   i_rst_n,
   // processor i/o cycle
   input  wire idio_pkg::idio_io_req_t i_io,
   output logic [7:0]                  o_io_rdata,
   output logic                        o_io_rvalid,
   // relay expander byte
   input  wire logic                   i_relay_wr,
   input  wire logic [7:0]             i_relay_data,
   // control input pins, active low
   input  wire logic [5:0]             i_ctl_in_a_n,
   input  wire logic [5:0]             i_ctl_in_b_n,
   input  wire logic [7:0]             i_internal_in,
   // output pins
   output logic [7:0]                  o_ctl_out_a_n,
   output logic [3:0]                  o_ctl_out_b_n,
   output logic [7:0]                  o_internal_out,
   output idio_pkg::idio_status_t      o_status_a,
   output logic [7:0]                  o_status_b,
   output logic [7:0]                  o_relay_n,
   output logic                        o_relay_active
);
   import idio_pkg::*;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   function automatic idio_sel_t idio_decode(input logic [IDIO_ADDR_W-1:0] addr);
      idio_sel_t sel;
      if (addr == IDIO_OFS_GROUP_A) begin
         sel = IDIO_SEL_GROUP_A;
      end else if (addr == IDIO_OFS_INTERNAL) begin
         sel = IDIO_SEL_INTERNAL;
      end else if (addr == IDIO_OFS_STATUS_A) begin
         sel = IDIO_SEL_STATUS_A;
      end else if (addr == IDIO_OFS_STATUS_B) begin
         sel = IDIO_SEL_STATUS_B;
      end else if (addr == IDIO_OFS_GROUP_B) begin
         sel = IDIO_SEL_GROUP_B;
      end else begin
         sel = IDIO_SEL_NONE;
      end
      return sel;
   endfunction : idio_decode

   // health is forced high by any alarm so a stale write cannot mask one
   function automatic idio_status_t idio_status_fix(input idio_status_t s);
      idio_status_t r;
      r = s;
      r.health_indicator = s.health_indicator | ~s.diagnostic_indicator
                         | ~s.thermal_alarm_indicator | ~s.pressure_alarm_indicator;
      return r;
   endfunction : idio_status_fix

   idio_sel_t    wr_sel;
   idio_sel_t    rd_sel;
   logic         wr_en;

   logic [7:0]   out_a;
   logic [7:0]   next_out_a;
   logic [3:0]   out_b;
   logic [3:0]   next_out_b;
   logic [7:0]   int_out;
   logic [7:0]   next_int_out;
   idio_status_t stat_a;
   idio_status_t next_stat_a;
   logic [7:0]   stat_b;
   logic [7:0]   next_stat_b;
   logic [7:0]   next_rdata;
   logic         next_rvalid;

   assign wr_sel = idio_decode(i_io.addr);
   assign rd_sel = wr_sel;
   assign wr_en  = i_io.wr;

   // ----------------------------------------
   // write side
   // ----------------------------------------
   always_comb begin
      // R15: every port holds unless addressed
      next_out_a   = out_a;
      next_out_b   = out_b;
      next_int_out = int_out;
      next_stat_a  = stat_a;
      next_stat_b  = stat_b;
      if (wr_en) begin
         case (wr_sel)
            // R3: eight active-low outputs
            IDIO_SEL_GROUP_A: begin
               next_out_a = i_io.wdata;
            end
            // R6: spare internal outputs
            IDIO_SEL_INTERNAL: begin
               next_int_out = i_io.wdata;
            end
            // R7: status bits as written, R8 R9 R10 R11 carried per field
            IDIO_SEL_STATUS_A: begin
               next_stat_a = idio_status_t'(i_io.wdata);
            end
            // R12: spare status port
            IDIO_SEL_STATUS_B: begin
               next_stat_b = i_io.wdata;
            end
            // R4: four outputs, upper nibble ignored
            IDIO_SEL_GROUP_B: begin
               next_out_b = i_io.wdata[IDIO_OUT_B_W-1:0];
            end
            default: begin
               next_out_a = out_a;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         out_a          <= IDIO_RELEASED;
         out_b          <= IDIO_OUT_B_PAD;
         int_out        <= IDIO_RELEASED;
         stat_a         <= idio_status_t'(IDIO_RELEASED);
         stat_b         <= IDIO_RELEASED;
         o_ctl_out_a_n  <= IDIO_RELEASED;
         o_ctl_out_b_n  <= IDIO_OUT_B_PAD;
         o_internal_out <= IDIO_RELEASED;
         o_status_a     <= idio_status_t'(IDIO_RELEASED);
         o_status_b     <= IDIO_RELEASED;
      end else begin
         out_a          <= next_out_a;
         out_b          <= next_out_b;
         int_out        <= next_int_out;
         stat_a         <= next_stat_a;
         stat_b         <= next_stat_b;
         o_ctl_out_a_n  <= next_out_a;
         o_ctl_out_b_n  <= next_out_b;
         o_internal_out <= next_int_out;
         // R7: alarm or diagnostics force health high
         o_status_a     <= idio_status_fix(next_stat_a);
         o_status_b     <= next_stat_b;
      end
   end

   // ----------------------------------------
   // read side
   // ----------------------------------------
   always_comb begin
      next_rvalid = i_io.rd;
      next_rdata  = IDIO_UNMAPPED_RD;
      if (i_io.rd) begin
         case (rd_sel)
            // R1: six inputs, top bits read one
            IDIO_SEL_GROUP_A: begin
               next_rdata = {IDIO_IN_PAD, i_ctl_in_a_n};
            end
            // R2: next six inputs, top bits read one
            IDIO_SEL_GROUP_B: begin
               next_rdata = {IDIO_IN_PAD, i_ctl_in_b_n};
            end
            // R5: spare internal inputs
            IDIO_SEL_INTERNAL: begin
               next_rdata = i_internal_in;
            end
            default: begin
               next_rdata = IDIO_UNMAPPED_RD;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_io_rdata  <= IDIO_UNMAPPED_RD;
         o_io_rvalid <= 1'b0;
      end else begin
         o_io_rdata  <= next_rdata;
         o_io_rvalid <= next_rvalid;
      end
   end

   // ----------------------------------------
   // relay board expander
   // ----------------------------------------
   // R13: keep-alive timing relies on the controller toggling bit 0
   idio_relay_wdog #(
      .WDOG_CYC (WDOG_CYC)
   ) u_relay (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_wr      (i_relay_wr),
      .i_data    (i_relay_data),
      .o_relay_n (o_relay_n),
      .o_active  (o_relay_active)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_in_a_read: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R1
      (i_io.rd && i_io.addr == IDIO_OFS_GROUP_A)
      |=> o_io_rvalid && o_io_rdata == {IDIO_IN_PAD, $past(i_ctl_in_a_n)})
      else $error("group a input read wrong");

   a_in_b_read: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R2
      (i_io.rd && i_io.addr == IDIO_OFS_GROUP_B)
      |=> o_io_rvalid && o_io_rdata == {IDIO_IN_PAD, $past(i_ctl_in_b_n)})
      else $error("group b input read wrong");

   a_out_a_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R3
      (i_io.wr && i_io.addr == IDIO_OFS_GROUP_A)
      |=> o_ctl_out_a_n == $past(i_io.wdata))
      else $error("group a outputs did not take the write");

   a_out_b_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R4
      (i_io.wr && i_io.addr == IDIO_OFS_GROUP_B)
      |=> o_ctl_out_b_n == $past(i_io.wdata[3:0]))
      else $error("group b outputs did not take the write");

   a_int_read: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R5
      (i_io.rd && i_io.addr == IDIO_OFS_INTERNAL)
      |=> o_io_rdata == $past(i_internal_in))
      else $error("internal input read wrong");

   a_int_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R6
      (i_io.wr && i_io.addr == IDIO_OFS_INTERNAL)
      |=> o_internal_out == $past(i_io.wdata))
      else $error("internal outputs did not take the write");

   a_health_forced: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R7
      (!o_status_a.diagnostic_indicator || !o_status_a.thermal_alarm_indicator
       || !o_status_a.pressure_alarm_indicator) |-> o_status_a.health_indicator)
      else $error("health shown ok during alarm or diagnostics");

   a_seq_bits: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R8
      (i_io.wr && i_io.addr == IDIO_OFS_STATUS_A)
      |=> o_status_a[7:2] == $past(i_io.wdata[7:2]))
      else $error("status indicator bits did not take the write");

   a_stat_b_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R12
      (i_io.wr && i_io.addr == IDIO_OFS_STATUS_B) |=> o_status_b == $past(i_io.wdata))
      else $error("second status port did not take the write");

   a_out_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R15
      (!i_io.wr) [*2] |-> $stable(o_ctl_out_a_n) && $stable(o_ctl_out_b_n)
                        && $stable(o_status_a) && $stable(o_internal_out))
      else $error("output port changed without a write");

endmodule : idio_ports

// *** hw/idio_relay_wdog.sv ***
// relay board expander output latch with its keep-alive watchdog
// assumes the expander byte arrives as a one-cycle write strobe with data
`timescale 1ns/1ps
module idio_relay_wdog #(
   parameter int WDOG_CYC = idio_pkg::IDIO_WDOG_CYC
) (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   // expander write
   input  wire logic       i_wr,
   input  wire logic [7:0] i_data,
   // relay pins
   output logic [7:0]      o_relay_n,
   output logic            o_active
);
   import idio_pkg::*;

   localparam int CNT_W = $clog2(WDOG_CYC + 1);

   generate
      if (WDOG_CYC < 2) begin : g_bad_cyc
         $error("idio_relay_wdog: WDOG_CYC must be at least 2");
      end
   endgenerate

   logic [7:0]       latch;
   logic [7:0]       next_latch;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic             active;
   logic             next_active;
   logic             toggled;

   // ----------------------------------------
   // watchdog and latch
   // ----------------------------------------
   always_comb begin
      toggled     = i_wr && (i_data[IDIO_RELAY_WDOG_BIT] != latch[IDIO_RELAY_WDOG_BIT]);
      next_latch  = i_wr ? i_data : latch;
      next_cnt    = cnt;
      next_active = active;
      // R13: keep-alive toggle restarts the timer
      if (toggled) begin
         next_cnt    = '0;
         next_active = 1'b1;
      end else if (cnt >= CNT_W'(WDOG_CYC - 1)) begin
         next_active = 1'b0;
      end else begin
         next_cnt = cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         latch    <= IDIO_RELEASED;
         cnt      <= '0;
         active   <= 1'b0;
         o_relay_n <= IDIO_RELEASED;
         o_active <= 1'b0;
      end else begin
         latch    <= next_latch;
         cnt      <= next_cnt;
         active   <= next_active;
         // R14: pump bit driven active low only while board is alive
         o_relay_n <= next_active ? next_latch : IDIO_RELEASED;
         o_active <= next_active;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_wdog_expire: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R13
      (!toggled && cnt >= CNT_W'(WDOG_CYC - 1)) |=> !o_active)
      else $error("relay board stayed active past the watchdog limit");

   a_pump_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R14
      (toggled) |=> o_active
                    && o_relay_n[IDIO_RELAY_PUMP_BIT] == $past(i_data[IDIO_RELAY_PUMP_BIT]))
      else $error("pump bit did not follow the expander write");

endmodule : idio_relay_wdog

// *** tb/idio_far_end.sv ***
// far-side equipment: control input pins and the relay keep-alive writer
// assumes the bench sets pin levels and turns the keep-alive on and off
`timescale 1ns/1ps
module idio_far_end #(
   parameter int PERIOD = 8
) (
   // clock
   input  wire logic       i_clk,
   // bench control
   input  wire logic [5:0] i_lvl_a_n,
   input  wire logic [5:0] i_lvl_b_n,
   input  wire logic [7:0] i_lvl_int,
   input  wire logic       i_keep,
   input  wire logic       i_pump_n,
   // pins toward the block
   output logic [5:0]      o_ctl_in_a_n,
   output logic [5:0]      o_ctl_in_b_n,
   output logic [7:0]      o_internal_in,
   output logic            o_relay_wr,
   output logic [7:0]      o_relay_data
);
   int   cnt = 0;
   logic wd  = 1'b1;

   assign o_ctl_in_a_n  = i_lvl_a_n;
   assign o_ctl_in_b_n  = i_lvl_b_n;
   assign o_internal_in = i_lvl_int;

   initial begin
      o_relay_wr   = 1'b0;
      o_relay_data = 8'hff;
   end

   // watchdog bit toggle
   // data is scrambled between writes so a stale byte is never mistaken for a write
   always @(negedge i_clk) begin
      if (i_keep && cnt >= PERIOD - 1) begin
         cnt          <= 0;
         wd           <= ~wd;
         o_relay_wr   <= 1'b1;
         o_relay_data <= {6'h3f, i_pump_n, ~wd};
      end else begin
         cnt          <= i_keep ? cnt + 1 : 0;
         o_relay_wr   <= 1'b0;
         o_relay_data <= ~o_relay_data;
      end
   end
endmodule : idio_far_end

// *** tb/instrument_digital_io_ports_tb_top.sv ***
// self-checking bench for the digital i/o ports
// assumes a short watchdog count and the far-side model in idio_far_end
`timescale 1ns/1ps
module instrument_digital_io_ports_tb_top;
   import idio_pkg::*;
   localparam int WDOG = 20;
   localparam int RP   = 8;

   logic         i_clk;
   logic         i_rst_n = 1'b0;
   idio_io_req_t io      = '0;
   logic [7:0]   rdata, int_out, st_b, relay_n, int_in, relay_data;
   logic [7:0]   out_a_n;
   logic [3:0]   out_b_n;
   logic [5:0]   in_a_n, in_b_n;
   logic [5:0]   lvl_a   = 6'h3f;
   logic [5:0]   lvl_b   = 6'h3f;
   logic [7:0]   lvl_int = 8'h00;
   logic         rvalid, active, relay_wr;
   logic         keep    = 1'b0;
   logic         pump_n  = 1'b1;
   idio_status_t st_a;
   int           n_mismatch = 0;
   int           samples_checked = 0;
   int           cycles = 0;

   idio_ports #(.WDOG_CYC(WDOG)) dut (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_io(io), .o_io_rdata(rdata),
      .o_io_rvalid(rvalid), .i_relay_wr(relay_wr), .i_relay_data(relay_data),
      .i_ctl_in_a_n(in_a_n), .i_ctl_in_b_n(in_b_n), .i_internal_in(int_in),
      .o_ctl_out_a_n(out_a_n), .o_ctl_out_b_n(out_b_n), .o_internal_out(int_out),
      .o_status_a(st_a), .o_status_b(st_b), .o_relay_n(relay_n),
      .o_relay_active(active));

   idio_far_end #(.PERIOD(RP)) far (
      .i_clk(i_clk), .i_lvl_a_n(lvl_a), .i_lvl_b_n(lvl_b), .i_lvl_int(lvl_int),
      .i_keep(keep), .i_pump_n(pump_n), .o_ctl_in_a_n(in_a_n),
      .o_ctl_in_b_n(in_b_n), .o_internal_in(int_in), .o_relay_wr(relay_wr),
      .o_relay_data(relay_data));

   // ----
   // clock, timeout, report
   // ----
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   // generous ceiling: the full sequence needs about 115 cycles
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic io_cyc(input logic rd, input logic wr, input logic [9:0] a,
                         input logic [7:0] d);
      @(negedge i_clk);
      io <= '{rd, wr, a, d};
      @(negedge i_clk);
      io <= '0;
   endtask : io_cyc

   task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
      io_cyc(1'b1, 1'b0, a, 8'h00);
      chk({rvalid, rdata}, {1'b1, exp});
   endtask : rd_chk

   // ----
   // scenarios
   // ----
   task automatic do_reset;
      @(negedge i_clk);
      i_rst_n = 1'b0;
      repeat (2) @(negedge i_clk);
      chk({out_a_n, int_out, st_a, st_b, relay_n, 3'h0, active, out_b_n, 7'h0, rvalid},
          56'hffffffffff0f00);
      i_rst_n = 1'b1;
   endtask : do_reset

   task automatic t_inputs;
      logic [5:0] pa[2] = '{6'h15, 6'h2a};
      for (int i = 0; i < 2; i++) begin
         lvl_a   = pa[i];
         lvl_b   = ~pa[i];
         lvl_int = {pa[i], 2'h1};
         rd_chk(IDIO_OFS_GROUP_A, {2'h3, pa[i]});
         rd_chk(IDIO_OFS_GROUP_B, {2'h3, ~pa[i]});
         rd_chk(IDIO_OFS_INTERNAL, {pa[i], 2'h1});
      end
      @(negedge i_clk);
      chk(rvalid, 1'b0);
      rd_chk(IDIO_OFS_STATUS_A, 8'hff);
      rd_chk(10'h320, 8'hff);
   endtask : t_inputs

   task automatic t_outputs;
      io_cyc(1'b1, 1'b1, IDIO_OFS_GROUP_A, 8'h5a);
      chk({rdata, out_a_n}, {2'h3, 6'h2a, 8'h5a});
      io_cyc(1'b0, 1'b1, IDIO_OFS_GROUP_B, 8'ha5);
      chk(out_b_n, 4'h5);
      io_cyc(1'b0, 1'b1, IDIO_OFS_INTERNAL, 8'h3c);
      chk(int_out, 8'h3c);
      io_cyc(1'b0, 1'b1, IDIO_OFS_STATUS_B, 8'hc3);
      chk(st_b, 8'hc3);
      io_cyc(1'b0, 1'b1, 10'h326, 8'h00);
      chk({out_a_n, out_b_n, int_out, st_b}, 28'h5a53cc3);
   endtask : t_outputs

   task automatic t_status;
      logic [7:0] v[6] = '{8'hfe, 8'hf6, 8'hee, 8'hde, 8'hfb, 8'h00};
      logic [7:0] e[6] = '{8'hfe, 8'hf7, 8'hef, 8'hdf, 8'hfb, 8'h01};
      foreach (v[i]) begin
         io_cyc(1'b0, 1'b1, IDIO_OFS_STATUS_A, v[i]);
         chk(st_a, e[i]);
      end
   endtask : t_status

   task automatic t_relay;
      chk({active, relay_n}, 9'h0ff);
      keep   <= 1'b1;
      pump_n <= 1'b0;
      repeat (2 * RP + 2) @(negedge i_clk);
      chk({active, relay_n | 8'h01}, 9'h1fd);
      pump_n <= 1'b1;
      repeat (2 * RP + 2) @(negedge i_clk);
      chk({active, relay_n | 8'h01}, 9'h1ff);
      keep   <= 1'b0;
      repeat (RP) @(negedge i_clk);
      chk(active, 1'b1);
      repeat (WDOG + 4) @(negedge i_clk);
      chk({active, relay_n}, 9'h0ff);
   endtask : t_relay

   initial begin
      do_reset();
      t_inputs();
      t_outputs();
      t_status();
      t_relay();
      do_reset();
      give_verdict();
   end
endmodule : instrument_digital_io_ports_tb_top
